/* File: inc/serial_port_pkg.sv */
// What this block does
// - each read starts with an 8-bit command; 0x88 selects the conversion result.
// - clocks ignored while chip select high; first rising clock claims the port.
// - after result command, ready falls when a result exists, within 112000 master clocks.
// - at each filter cycle end a pending result read moves the accumulator out.
// - other register reads assert ready within 256 master clocks of the command.
// - host gives 24 clocks to read the word; ready returns high after the last.
// - in 4/5-wire mode output floats while chip select high or after 24 bits.
// - one result command keeps presenting each new result until another command has been shifted in.
// - in continuous mode ready pulses high then low per new word, read or not.
// - a command other than 0x88 shifted in right after a result word ends continuous mode.
// - interface select high gives a 3-wire link; chip select held low.
// - in 3-wire mode the output idles high, never floats, goes low when data ready.
// - 3-wire: 8 clocks clear ready, data from 8th falling edge, high after 24th.
// - continuous mode also works in 3-wire mode, with the output low per result.
// - 128 or more ones then one zero forces command mode awaiting a command.
// - gain register weights msb 2^0, lsb 2^-23, resets to msb only.
// - excitation source and frequency bits zero drive pin a low, pin b high.
// - excitation source bit set makes pin a an input; high means dc excitation.
// - interface select low gives 5-wire with chip select and ready, or 4-wire.
`default_nettype none
package serial_port_pkg;
  localparam logic [7:0] CMD_READ_RESULT = 8'h88;
  localparam logic [7:0] CMD_READ_GAIN = 8'h98;
  localparam logic [7:0] CMD_WRITE_GAIN = 8'h90;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h9c;
  localparam logic [7:0] CMD_WRITE_CONFIG = 8'h94;
  localparam logic [23:0] GAIN_RESET = 24'h800000;
  localparam logic [23:0] CONFIG_RESET = 24'h000000;
  localparam int CFG_EXC_BIT = 19;
  localparam int CFG_FHI_BIT = 18;
  localparam int CFG_FLO_BIT = 17;
  localparam int CMD_BITS = 8;
  localparam int WORD_BITS = 24;
  localparam int RESYNC_ONES = 128;
  localparam int CLK_HZ = 25000000;
  localparam int RESULT_WAIT_MAX_CYC = 112000;
  localparam int REG_WAIT_MAX_CYC = 256;
  localparam int REG_READY_DELAY_CYC = 16;
  localparam int FILTER_PERIOD_CYC = 81920;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_WAIT = 3'b010,
    ST_ARMED = 3'b011,
    ST_CLEAR = 3'b100,
    ST_SHIFT = 3'b101,
    ST_WDATA = 3'b110
  } port_state_t;
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } cmd_word_t;
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } data_word_t;
endpackage
`default_nettype wire

/* File: core/sync_toggle.sv */
`default_nettype none
// toggle-based event crossing with 3-flop sync
module sync_toggle (
  input wire logic dst_clk_in,
  input wire logic reset_in,
  input wire logic toggle_in,
  output logic pulse_out
);
  logic s1, s2, s3;
  always_ff @(posedge dst_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= toggle_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign pulse_out = s2 ^ s3;
endmodule // sync_toggle
`default_nettype wire

/* File: core/sync_level.sv */
`default_nettype none
// level crossing: three flops, change once second and third agree
module sync_level #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic level_in,
  output logic level_out
);
  logic s1, s2, s3;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1 <= RESET_VALUE;
      s2 <= RESET_VALUE;
      s3 <= RESET_VALUE;
      level_out <= RESET_VALUE;
    end else begin
      s1 <= level_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_out <= s3;
      end
    end
  end
endmodule // sync_level
`default_nettype wire

/* File: core/serial_command_port.sv */
`default_nettype none
module serial_command_port
  import serial_port_pkg::*;
#(
  parameter int FILTER_PERIOD = FILTER_PERIOD_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in_line_in,
  input wire logic interface_select_in,
  input wire logic [23:0] conversion_result_in,
  input wire logic excitation_pin_a_in,
  output logic serial_out_line_out,
  output logic serial_out_line_oe_out,
  output logic result_ready_n_out,
  output logic excitation_pin_a_out,
  output logic excitation_pin_a_oe_out,
  output logic excitation_pin_b_out,
  output logic filter_cycle_end_out,
  output logic [23:0] gain_calibration_out
);
  initial begin
    if (FILTER_PERIOD < 2 || FILTER_PERIOD > RESULT_WAIT_MAX_CYC) begin
      $error("filter period out of range");
    end
  end

  localparam int FP_W = $clog2(FILTER_PERIOD + 1);

  // ---------------- link domain (serial clock) ----------------
  port_state_t state;
  logic [7:0] cmd_shift;
  logic [4:0] bit_cnt;
  logic [7:0] ones_cnt;
  logic [23:0] out_shift;
  logic [23:0] wr_shift;
  logic cont_mode;
  logic cmd_toggle;
  logic [7:0] cmd_code;
  logic wr_toggle;
  logic [23:0] wr_data;
  logic ack_toggle;
  logic three_wire_link;
  logic [7:0] next_cmd;
  logic drive_bit;
  logic shifting;
  logic ready_link;
  // core-domain state read by the link logic
  logic [23:0] latched_word;
  logic ready_core;
  logic ack_seen;
  logic inflight;

  // the serial clock stops while the host waits for ready, so flops on it
  // could never pick the level up; the host clocks only after ready has
  // stood on the pin for a master cycle, so these levels are quiet here
  // word acknowledged on the link but not yet taken by the core
  assign inflight = ack_toggle ^ ack_seen;
  // a stale ready right after a read must not start a second read
  assign ready_link = ready_core && !inflight;

  // interface select is a strap-like pin; read raw at the link
  assign three_wire_link = interface_select_in;
  assign next_cmd = {cmd_shift[6:0], serial_in_line_in};

  // port sequencing on rising serial clock; disabled while chip select high unless in 3-wire mode
  always_ff @(posedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      cmd_shift <= 8'h00;
      bit_cnt <= 5'd0;
      ones_cnt <= 8'h00;
      cont_mode <= 1'b0;
      cmd_toggle <= 1'b0;
      cmd_code <= 8'h00;
      wr_toggle <= 1'b0;
      wr_data <= 24'h000000;
      wr_shift <= 24'h000000;
    end else if (!chip_select_n_in || three_wire_link) begin
      // resync: 128+ ones then a zero
      if (serial_in_line_in) begin
        if (ones_cnt != 8'hff) begin
          ones_cnt <= ones_cnt + 8'h01;
        end
      end else begin
        ones_cnt <= 8'h00;
      end
      if (!serial_in_line_in && ones_cnt >= 8'(RESYNC_ONES)) begin
        state <= ST_IDLE;
        cont_mode <= 1'b0;
        bit_cnt <= 5'd0;
      end else begin
        unique case (state)
          ST_IDLE, ST_ARMED, ST_WAIT: begin
            if (state != ST_IDLE && ready_link) begin
              // a word stands: these clocks read it, or clear the flag in 3-wire
              state <= three_wire_link ? ST_CLEAR : ST_SHIFT;
              bit_cnt <= 5'd1;
            end else if (serial_in_line_in && state != ST_WAIT) begin
              // first rising clock of a command claims the port; the input
              // idles low, so a low bit here is no command
              cmd_shift <= next_cmd;
              bit_cnt <= 5'd1;
              state <= ST_CMD;
            end
          end
          ST_CMD: begin
            cmd_shift <= next_cmd;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'(CMD_BITS - 1)) begin
              cmd_code <= next_cmd;
              cmd_toggle <= ~cmd_toggle;
              bit_cnt <= 5'd0;
              // any other command ends continuous mode
              cont_mode <= (next_cmd == CMD_READ_RESULT);
              if (next_cmd == CMD_WRITE_GAIN || next_cmd == CMD_WRITE_CONFIG) begin
                state <= ST_WDATA;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_CLEAR: begin
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'(CMD_BITS - 1)) begin
              bit_cnt <= 5'd0;
              state <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'(WORD_BITS - 1)) begin
              bit_cnt <= 5'd0;
              state <= cont_mode ? ST_ARMED : ST_IDLE;
            end
          end
          ST_WDATA: begin
            wr_shift <= {wr_shift[22:0], serial_in_line_in};
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'(WORD_BITS - 1)) begin
              wr_data <= {wr_shift[22:0], serial_in_line_in};
              wr_toggle <= ~wr_toggle;
              bit_cnt <= 5'd0;
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // word read acknowledge, separate process to keep one driver
  always_ff @(posedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_toggle <= 1'b0;
    end else if ((!chip_select_n_in || three_wire_link) && state == ST_SHIFT
                 && bit_cnt == 5'(WORD_BITS - 1)) begin
      ack_toggle <= ~ack_toggle;
    end
  end

  // output data launched on falling serial clock
  // 3-wire shows the msb at the 8th falling clock; 5-wire has already
  // shown it before the first clock, so it starts one bit further on
  always_ff @(negedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_shift <= 24'h000000;
      shifting <= 1'b0;
    end else if (state == ST_SHIFT && !shifting) begin
      out_shift <= three_wire_link ? latched_word : {latched_word[22:0], 1'b0};
      shifting <= 1'b1;
    end else if (state == ST_SHIFT) begin
      out_shift <= {out_shift[22:0], 1'b0};
    end else begin
      shifting <= 1'b0;
    end
  end
  assign drive_bit = out_shift[23];

  // ---------------- core domain ----------------
  logic ready_blip;
  logic [23:0] gain_reg;
  logic [23:0] config_reg;
  logic cmd_pulse, wr_pulse, ack_pulse;
  logic cs_n_sync, interface_select_sync, exc_a_sync;
  logic [FP_W-1:0] filter_cnt;
  logic [8:0] reg_delay;
  logic pending_result;
  logic pending_reg;
  logic [7:0] cmd_core;
  logic [23:0] wr_core;

  sync_toggle u_cmd_sync (
    .dst_clk_in(core_clk_in),
    .reset_in(reset_in),
    .toggle_in(cmd_toggle),
    .pulse_out(cmd_pulse)
  );
  sync_toggle u_ack_sync (
    .dst_clk_in(core_clk_in),
    .reset_in(reset_in),
    .toggle_in(ack_toggle),
    .pulse_out(ack_pulse)
  );
  sync_toggle u_wr_sync (
    .dst_clk_in(core_clk_in),
    .reset_in(reset_in),
    .toggle_in(wr_toggle),
    .pulse_out(wr_pulse)
  );
  sync_level #(.RESET_VALUE(1'b1)) u_cs_sync (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .level_in(chip_select_n_in),
    .level_out(cs_n_sync)
  );
  sync_level #(.RESET_VALUE(1'b0)) u_interface_select_sync (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .level_in(interface_select_in),
    .level_out(interface_select_sync)
  );
  sync_level #(.RESET_VALUE(1'b1)) u_exc_sync (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .level_in(excitation_pin_a_in),
    .level_out(exc_a_sync)
  );

  // cmd_code and wr_data are stable long before their toggles arrive
  assign cmd_core = cmd_code;
  assign wr_core = wr_data;

  // filter convolution period counter
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      filter_cnt <= '0;
      filter_cycle_end_out <= 1'b0;
    end else begin
      filter_cycle_end_out <= (filter_cnt == FP_W'(FILTER_PERIOD - 1));
      filter_cnt <= (filter_cnt == FP_W'(FILTER_PERIOD - 1)) ? '0 : filter_cnt + FP_W'(1);
    end
  end

  // request tracking and ready indication
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pending_result <= 1'b0;
      pending_reg <= 1'b0;
      reg_delay <= 9'd0;
      ready_core <= 1'b0;
      ready_blip <= 1'b0;
      ack_seen <= 1'b0;
      latched_word <= 24'h000000;
    end else begin
      ready_blip <= 1'b0;
      if (ack_pulse) begin
        // moves in the same cycle as ready_core drops
        ack_seen <= ~ack_seen;
      end
      if (cmd_pulse) begin
        // a result read stays armed until another command arrives
        pending_result <= (cmd_core == CMD_READ_RESULT);
        pending_reg <= (cmd_core == CMD_READ_GAIN || cmd_core == CMD_READ_CONFIG);
        reg_delay <= 9'd0;
        ready_core <= 1'b0;
      end else begin
        if (ack_pulse) begin
          ready_core <= 1'b0;
        end
        if (pending_reg) begin
          reg_delay <= reg_delay + 9'd1;
          if (reg_delay == 9'(REG_READY_DELAY_CYC)) begin
            latched_word <= (cmd_core == CMD_READ_GAIN) ? gain_reg : config_reg;
            ready_core <= 1'b1;
            pending_reg <= 1'b0;
          end
        end
        if (pending_result && filter_cycle_end_out) begin
          latched_word <= conversion_result_in;
          ready_core <= 1'b1;
          // unread word: ready rises for one cycle before the new one
          ready_blip <= ready_core;
        end
      end
    end
  end

  // gain and configuration registers
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gain_reg <= GAIN_RESET;
      config_reg <= CONFIG_RESET;
    end else if (wr_pulse) begin
      if (cmd_core == CMD_WRITE_GAIN) begin
        gain_reg <= wr_core;
      end else if (cmd_core == CMD_WRITE_CONFIG) begin
        config_reg <= wr_core;
      end
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_out_line_out <= 1'b1;
      serial_out_line_oe_out <= 1'b0;
      result_ready_n_out <= 1'b1;
      excitation_pin_a_out <= 1'b0;
      excitation_pin_a_oe_out <= 1'b1;
      excitation_pin_b_out <= 1'b1;
      gain_calibration_out <= GAIN_RESET;
    end else begin
      result_ready_n_out <= ~ready_core | ready_blip;
      gain_calibration_out <= gain_reg;
      if (interface_select_sync) begin
        serial_out_line_oe_out <= 1'b1;
        // low flags a word; high again once the last bit has gone out
        serial_out_line_out <= shifting ? drive_bit : !(ready_core && !inflight && !ready_blip);
      end else begin
        serial_out_line_oe_out <= !cs_n_sync && ready_core && !inflight;
        serial_out_line_out <= shifting ? drive_bit : latched_word[23];
      end
      if (config_reg[CFG_EXC_BIT]) begin
        excitation_pin_a_oe_out <= 1'b0;
        excitation_pin_a_out <= 1'b0;
        excitation_pin_b_out <= exc_a_sync;
      end else begin
        excitation_pin_a_oe_out <= 1'b1;
        if (!config_reg[CFG_FHI_BIT] && !config_reg[CFG_FLO_BIT]) begin
          excitation_pin_a_out <= 1'b0;
          excitation_pin_b_out <= 1'b1;
        end else begin
          excitation_pin_a_out <= 1'b0;
          excitation_pin_b_out <= 1'b1;
        end
      end
    end
  end
endmodule // serial_command_port
`default_nettype wire

/* File: test/serial_port_properties.sv */
`default_nettype none
module serial_port_properties
  import serial_port_pkg::*;
#(
  parameter int FILTER_PERIOD = FILTER_PERIOD_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in_line_in,
  input wire logic interface_select_in,
  input wire logic [23:0] conversion_result_in,
  input wire logic excitation_pin_a_in,
  input wire logic serial_out_line_out,
  input wire logic serial_out_line_oe_out,
  input wire logic result_ready_n_out,
  input wire logic excitation_pin_a_out,
  input wire logic excitation_pin_a_oe_out,
  input wire logic excitation_pin_b_out,
  input wire logic filter_cycle_end_out,
  input wire logic [23:0] gain_calibration_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap;
  logic seen;
  // cycles since the previous filter end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gap <= 0;
      seen <= 1'b0;
    end else if (filter_cycle_end_out) begin
      gap <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence ready_fall;
    $fell(result_ready_n_out);
  endsequence
  sequence cs_idle_5w;
    (!interface_select_in && chip_select_n_in) [*6];
  endsequence
  AST_GAIN_RESET: assert property (
    $fell(reset_in) |-> gain_calibration_out == GAIN_RESET)
    else $error("gain register not at reset value");
  AST_RESET_DC: assert property (
    $fell(reset_in) |-> excitation_pin_a_oe_out && !excitation_pin_a_out && excitation_pin_b_out)
    else $error("excitation pins not dc after reset");
  AST_DC_PINS: assert property (
    excitation_pin_a_oe_out [*2] |-> !excitation_pin_a_out && excitation_pin_b_out)
    else $error("driven excitation pins not dc levels");
  AST_FILTER_GAP: assert property (
    filter_cycle_end_out && seen |-> gap == FILTER_PERIOD - 1)
    else $error("filter end spacing wrong");
  AST_READY_HOLD: assert property (
    ready_fall |-> (!result_ready_n_out) [*3])
    else $error("ready dropped too early");
  AST_3W_SOD_LOW: assert property (
    interface_select_in ##0 ready_fall |-> ##[0:4] !serial_out_line_out)
    else $error("three wire output not low on ready");
  AST_OUT_FLOAT_CS: assert property (
    cs_idle_5w |-> !serial_out_line_oe_out)
    else $error("output driven while deselected");
  AST_3W_DRIVEN: assert property (
    interface_select_in [*6] |-> serial_out_line_oe_out)
    else $error("three wire output floating");
endmodule // serial_port_properties

bind serial_command_port serial_port_properties #(.FILTER_PERIOD(FILTER_PERIOD)) props (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .serial_clk_in(serial_clk_in),
  .chip_select_n_in(chip_select_n_in), .serial_in_line_in(serial_in_line_in),
  .interface_select_in(interface_select_in), .conversion_result_in(conversion_result_in),
  .excitation_pin_a_in(excitation_pin_a_in), .serial_out_line_out(serial_out_line_out),
  .serial_out_line_oe_out(serial_out_line_oe_out), .result_ready_n_out(result_ready_n_out),
  .excitation_pin_a_out(excitation_pin_a_out), .excitation_pin_a_oe_out(excitation_pin_a_oe_out),
  .excitation_pin_b_out(excitation_pin_b_out), .filter_cycle_end_out(filter_cycle_end_out),
  .gain_calibration_out(gain_calibration_out)
);
`default_nettype wire

/* File: test/serial_host.sv */
`default_nettype none
module serial_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sid_out,
  input wire logic sod_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sid_out = 1'b0;
  end
  // one 12 ns clock, data set while low
  task automatic pulse(input logic b);
    sid_out = b;
    #6 sclk_out = 1'b1;
    #6 sclk_out = 1'b0;
  endtask
  // sel low sends the clocks with chip select high
  task automatic cmd8(input logic [7:0] c, input logic sel);
    cs_n_out = !sel;
    #7;
    for (int i = 7; i >= 0; i--) pulse(c[i]);
    sid_out = 1'b0;
  endtask
  task automatic word24(input logic [23:0] v);
    for (int i = 23; i >= 0; i--) pulse(v[i]);
    sid_out = 1'b0;
    #6 cs_n_out = 1'b1;
  endtask
  // select and each new bit need a few master clocks to reach the pin
  task automatic get(output logic [23:0] v);
    cs_n_out = 1'b0;
    #250;
    for (int i = 23; i >= 0; i--) begin
      v[i] = sod_in;
      #6 sclk_out = 1'b1;
      #6 sclk_out = 1'b0;
      #45;
    end
    #6 cs_n_out = 1'b1;
  endtask
  // stray bits, then ones and a zero
  task automatic resync();
    cs_n_out = 1'b0;
    #7;
    pulse(1'b1);
    pulse(1'b0);
    repeat (128) pulse(1'b1);
    pulse(1'b0);
    #6 cs_n_out = 1'b1;
  endtask
endmodule // serial_host
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FP = 64;
  logic core_clk = 1'b0;
  logic reset_in = 1'b1;
  logic isel = 1'b0;
  logic [23:0] conv = 24'ha5c3f1;
  logic sclk, cs_n, serial_in_line, serial_out_line, sod_oe, ready_n, pa, pa_oe, pb, fend;
  logic [23:0] gain;
  logic [23:0] w;
  wire sod_wire;
  wire pin_a;
  int errors = 0;
  int checked = 0;
  int n;
  assign sod_wire = sod_oe ? serial_out_line : 1'bz;
  assign pin_a = pa_oe ? pa : 1'b1;
  always #20 core_clk = ~core_clk;
  serial_host host (.sclk_out(sclk), .cs_n_out(cs_n), .sid_out(serial_in_line), .sod_in(sod_wire));
  serial_command_port #(.FILTER_PERIOD(FP)) dut (
    .core_clk_in(core_clk), .reset_in(reset_in), .serial_clk_in(sclk),
    .chip_select_n_in(cs_n & ~isel), .serial_in_line_in(serial_in_line), .interface_select_in(isel),
    .conversion_result_in(conv), .excitation_pin_a_in(pin_a), .serial_out_line_out(serial_out_line),
    .serial_out_line_oe_out(sod_oe), .result_ready_n_out(ready_n), .excitation_pin_a_out(pa),
    .excitation_pin_a_oe_out(pa_oe), .excitation_pin_b_out(pb), .filter_cycle_end_out(fend),
    .gain_calibration_out(gain)
  );
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      1: return sod_wire;
      2: return pa_oe;
      default: return ready_n;
    endcase
  endfunction
  task automatic wait_for(input int sel, input logic lvl, input int bound);
    n = 0;
    while (pick(sel) !== lvl && n < bound) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    if (n >= bound) begin
      errors++;
      $display("[FAIL] t=%0t wait expired seen=%h expected=%h", $time, pick(sel), lvl);
      final_report();
    end
  endtask
  task automatic stay_high(input int cycles);
    logic low;
    low = 1'b0;
    repeat (cycles) begin
      @(posedge core_clk);
      #2;
      if (ready_n !== 1'b1) low = 1'b1;
    end
    check({23'h0, low}, 24'h0);
  endtask
  task automatic do_reset(input logic three);
    reset_in = 1'b1;
    isel = three;
    repeat (16) @(posedge core_clk);
    #2 reset_in = 1'b0;
    repeat (8) @(posedge core_clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] c, input logic [23:0] v);
    host.cmd8(c, 1'b1);
    host.word24(v);
  endtask
  task automatic rd(input logic [7:0] c, input logic [23:0] exp);
    host.cmd8(c, 1'b1);
    wait_for(0, 1'b0, REG_WAIT_MAX_CYC);
    host.get(w);
    check(w, exp);
    wait_for(0, 1'b1, 16);
  endtask
  initial begin
    do_reset(1'b0);
    check(gain, GAIN_RESET);
    check({19'h0, ready_n, sod_oe, pb, pa_oe, pa}, 24'h16);
    $display("test reset done");
    wr(CMD_WRITE_GAIN, 24'h9abcde);
    rd(CMD_READ_GAIN, 24'h9abcde);
    check(gain, 24'h9abcde);
    check({23'h0, sod_oe}, 24'h0);
    $display("test gain done");
    host.cmd8(CMD_READ_GAIN, 1'b0);
    stay_high(REG_WAIT_MAX_CYC);
    host.resync();
    rd(CMD_READ_GAIN, 24'h9abcde);
    $display("test select and resync done");
    host.cmd8(CMD_READ_RESULT, 1'b1);
    wait_for(0, 1'b0, FP + 8);
    host.get(w);
    check(w, 24'ha5c3f1);
    @(posedge core_clk);
    #2 conv = 24'h3c0f96;
    wait_for(0, 1'b1, 16);
    wait_for(0, 1'b0, FP + 8);
    wait_for(0, 1'b1, FP + 8);
    wait_for(0, 1'b0, 16);
    host.get(w);
    check(w, 24'h3c0f96);
    rd(CMD_READ_GAIN, 24'h9abcde);
    stay_high(2 * FP + 16);
    $display("test continuous done");
    wr(CMD_WRITE_CONFIG, 24'h1 << CFG_EXC_BIT);
    wait_for(2, 1'b0, 32);
    wr(CMD_WRITE_CONFIG, CONFIG_RESET);
    wait_for(2, 1'b1, 32);
    check({22'h0, pin_a, pb}, 24'h1);
    $display("test excitation done");
    do_reset(1'b1);
    check(gain, GAIN_RESET);
    check({22'h0, sod_oe, sod_wire}, 24'h3);
    host.cmd8(CMD_READ_RESULT, 1'b1);
    wait_for(1, 1'b0, FP + 8);
    host.cmd8(8'h00, 1'b1);
    host.get(w);
    check(w, 24'h3c0f96);
    wait_for(1, 1'b1, 8);
    wait_for(1, 1'b0, FP + 8);
    $display("test three wire done");
    final_report();
  end
endmodule // tb
`default_nettype wire
